// [common/trsp_pkg.sv]
`default_nettype none

package trsp_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RECALL = 8'h08;

  // Control register fields
  localparam int CTRL_PASS_LATCH_BIT = 0;
  localparam int CTRL_FAIL_LOCK_BIT  = 1;
  localparam int CTRL_CLEAR_BIT      = 2;
  localparam logic [1:0] CTRL_RESET  = 2'h0;

  // Status register fields
  localparam int STAT_TEST_BIT    = 0;
  localparam int STAT_LIVE_BIT    = 1;
  localparam int STAT_PASS_BIT    = 2;
  localparam int STAT_UFAIL_BIT   = 3;
  localparam int STAT_LFAIL_BIT   = 4;
  localparam int STAT_STANDBY_BIT = 5;
  localparam int STAT_ENABLE_BIT  = 6;
  localparam int STAT_INVALID_BIT = 7;

  // Recall register fields
  localparam int RCL_DIGIT_LSB   = 0;
  localparam int RCL_INVALID_BIT = 4;

  // Recall select code
  localparam int SEL_W                 = 4;
  localparam logic [3:0] BCD_MAX       = 4'h9;
  localparam logic [3:0] RECALL_RESET  = 4'h0;

  // Synchroniser lanes and idle levels (selects idle high)
  localparam int SYNC_W          = 8;
  localparam int SYN_SEL_LSB     = 0;
  localparam int SYN_STROBE_BIT  = 4;
  localparam int SYN_START_BIT   = 5;
  localparam int SYN_STOP_BIT    = 6;
  localparam int SYN_ENABLE_BIT  = 7;
  localparam logic [7:0] SYNC_RESET = 8'h0F;

  // PASS pulse length
  localparam int unsigned CLK_FREQ_HZ       = 125_000_000;
  localparam int unsigned PASS_PULSE_TIME_MS = 200;
  localparam int unsigned PASS_PULSE_CYCLES  = PASS_PULSE_TIME_MS * (CLK_FREQ_HZ / 1000);

  // Test sequencing
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_TEST
  } trsp_state_t;

endpackage

`default_nettype wire

// [common/trsp_sync_if.sv]
`default_nettype none

// Raw pin levels in, synchronised levels out
interface trsp_sync_if #(
  parameter int W = 8
);
  logic [W-1:0] async_d;
  logic [W-1:0] sync_q;

  modport src (output async_d, input sync_q);
  modport dst (input async_d, output sync_q);
endinterface

`default_nettype wire

// [hdl/trsp_sync.sv]
`default_nettype none

module trsp_sync #(
  parameter int             W         = 8,
  parameter logic [W-1:0]   RESET_VAL = '0
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  trsp_sync_if.dst  sync_port
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage1_next;
  logic [W-1:0] stage2_reg;
  logic [W-1:0] stage2_next;

  // Two-stage chain; only stage two is visible outside
  always_comb begin
    stage1_next = sync_port.async_d;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign sync_port.sync_q = stage2_reg;

endmodule

`default_nettype wire

// [hdl/trsp_top.sv]
// Function
// - Select code: one active-low BCD digit, bit0 LSB
// - Strobe rise captures select, loads stored condition
// - Live flag during test and residue; test flag
// - PASS pulse about 0.2 s, or held
// - Above upper limit: hold upper fail
// - At or below lower limit: hold lower fail
// - Remote start begins test like panel start
// - Remote stop ends test, returns to standby
// - Remote start/stop need remote enable held
// - Fail lock: remote stop keeps FAIL judgment
// - Pass latch picks 0.2 s or indefinite
//
// Chosen here: the register offsets and the strobed register port.
`default_nettype none

module trsp_top
  import trsp_pkg::*;
#(
  parameter int unsigned PASS_CYC = PASS_PULSE_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              recall_select_bit0_b_i,
  input  wire logic              recall_select_bit1_b_i,
  input  wire logic              recall_select_bit2_b_i,
  input  wire logic              recall_select_bit3_b_i,
  input  wire logic              recall_strobe_i,
  input  wire logic              remote_start_i,
  input  wire logic              remote_stop_i,
  input  wire logic              remote_enable_i,
  input  wire logic              panel_start_i,
  input  wire logic              panel_stop_i,
  input  wire logic              meas_done_i,
  input  wire logic              meas_over_upper_i,
  input  wire logic              meas_at_or_below_lower_i,
  input  wire logic              hv_residual_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output var  logic [DATA_W-1:0] reg_rdata_o,
  output var  logic              output_live_flag_o,
  output var  logic              test_active_o,
  output var  logic              pass_o,
  output var  logic              upper_fail_o,
  output var  logic              lower_fail_o,
  output var  logic              standby_o,
  output var  logic              recall_load_o,
  output var  logic [SEL_W-1:0]  recall_index_o
);

  localparam int TW = $clog2(PASS_CYC + 1);
  localparam logic [TW-1:0] PASS_LOAD = TW'(PASS_CYC - 1);
  localparam logic [TW-1:0] TIMER_ZERO = '0;

  // Synchronised remote inputs
  trsp_sync_if #(.W(SYNC_W)) sync_bus ();

  logic [SYNC_W-1:0] s_q;
  logic [SEL_W-1:0]  s_sel_b;
  logic              s_strobe;
  logic              s_start;
  logic              s_stop;
  logic              s_enable;

  // Edge detection
  logic [2:0] prev_reg;
  logic [2:0] prev_next;
  logic       strobe_rise;
  logic       start_rise;
  logic       stop_rise;

  // Command decode
  logic start_req;
  logic stop_remote;
  logic stop_any;
  logic fail_held;
  logic clear_req;

  // Test and judgment state
  trsp_state_t    state_reg;
  trsp_state_t    state_next;
  logic           pass_reg;
  logic           pass_next;
  logic           ufail_reg;
  logic           ufail_next;
  logic           lfail_reg;
  logic           lfail_next;
  logic [TW-1:0]  timer_reg;
  logic [TW-1:0]  timer_next;
  logic           live_reg;
  logic           live_next;
  logic           standby_reg;
  logic           standby_next;

  // Recall state
  logic [SEL_W-1:0] digit;
  logic [SEL_W-1:0] last_reg;
  logic [SEL_W-1:0] last_next;
  logic             invalid_reg;
  logic             invalid_next;
  logic             load_reg;
  logic             load_next;
  logic [SEL_W-1:0] index_reg;
  logic [SEL_W-1:0] index_next;

  // Register bus state
  logic [1:0]        ctrl_reg;
  logic [1:0]        ctrl_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              pass_latch;
  logic              fail_lock;

  // Pins into the synchroniser
  assign sync_bus.async_d = {remote_enable_i, remote_stop_i, remote_start_i,
                             recall_strobe_i, recall_select_bit3_b_i,
                             recall_select_bit2_b_i, recall_select_bit1_b_i,
                             recall_select_bit0_b_i};

  trsp_sync #(
    .W         (SYNC_W),
    .RESET_VAL (SYNC_RESET)
  ) u_sync (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .sync_port (sync_bus)
  );

  // Unpack synchronised lanes
  assign s_q      = sync_bus.sync_q;
  assign s_sel_b  = s_q[SYN_SEL_LSB +: SEL_W];
  assign s_strobe = s_q[SYN_STROBE_BIT];
  assign s_start  = s_q[SYN_START_BIT];
  assign s_stop   = s_q[SYN_STOP_BIT];
  assign s_enable = s_q[SYN_ENABLE_BIT];

  assign pass_latch = ctrl_reg[CTRL_PASS_LATCH_BIT];
  assign fail_lock  = ctrl_reg[CTRL_FAIL_LOCK_BIT];

  // Edges seen only on synchronised levels
  always_comb begin
    prev_next   = {s_stop, s_start, s_strobe};
    strobe_rise = s_strobe & ~prev_reg[0];
    start_rise  = s_start & ~prev_reg[1];
    stop_rise   = s_stop & ~prev_reg[2];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      prev_reg <= 3'h0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  // Start and stop sources
  always_comb begin
    start_req   = panel_start_i | (s_enable & start_rise);
    stop_remote = s_enable & stop_rise;
    stop_any    = panel_stop_i | stop_remote;
    fail_held   = ufail_reg | lfail_reg;
    clear_req   = reg_wr_i && (reg_addr_i == REG_CTRL) && reg_wdata_i[CTRL_CLEAR_BIT];
  end

  // Test sequencing and judgment
  always_comb begin
    state_next = state_reg;
    pass_next  = pass_reg;
    ufail_next = ufail_reg;
    lfail_next = lfail_reg;
    timer_next = timer_reg;
    // PASS pulse countdown unless latched
    if (pass_reg && !pass_latch) begin
      if (timer_reg == TIMER_ZERO) begin
        pass_next = 1'b0;
      end else begin
        timer_next = timer_reg - TW'(1);
      end
    end
    // Software clear of held judgments
    if (clear_req) begin
      pass_next  = 1'b0;
      ufail_next = 1'b0;
      lfail_next = 1'b0;
    end
    if (stop_any) begin
      state_next = ST_IDLE;
      pass_next  = 1'b0;
      if (panel_stop_i || !fail_lock) begin
        ufail_next = 1'b0;
        lfail_next = 1'b0;
      end
    end else if (state_reg == ST_TEST) begin
      if (meas_done_i) begin
        state_next = ST_IDLE;
        if (meas_over_upper_i) begin
          ufail_next = 1'b1;
        end else if (meas_at_or_below_lower_i) begin
          lfail_next = 1'b1;
        end else begin
          pass_next  = 1'b1;
          timer_next = PASS_LOAD;
        end
      end
    end else if (start_req && !fail_held) begin
      state_next = ST_TEST;
      pass_next  = 1'b0;
    end
    live_next    = (state_next == ST_TEST) | hv_residual_i;
    standby_next = (state_next == ST_IDLE) && !(pass_next | ufail_next | lfail_next);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_reg   <= ST_IDLE;
      pass_reg    <= 1'b0;
      ufail_reg   <= 1'b0;
      lfail_reg   <= 1'b0;
      timer_reg   <= TIMER_ZERO;
      live_reg    <= 1'b0;
      standby_reg <= 1'b1;
    end else begin
      state_reg   <= state_next;
      pass_reg    <= pass_next;
      ufail_reg   <= ufail_next;
      lfail_reg   <= lfail_next;
      timer_reg   <= timer_next;
      live_reg    <= live_next;
      standby_reg <= standby_next;
    end
  end

  // Stored-condition recall on strobe rise
  always_comb begin
    digit        = ~s_sel_b;
    last_next    = last_reg;
    invalid_next = invalid_reg;
    load_next    = 1'b0;
    index_next   = index_reg;
    if (strobe_rise) begin
      last_next = digit;
      if (digit <= BCD_MAX) begin
        load_next    = 1'b1;
        index_next   = digit;
        invalid_next = 1'b0;
      end else begin
        invalid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      last_reg    <= RECALL_RESET;
      invalid_reg <= 1'b0;
      load_reg    <= 1'b0;
      index_reg   <= RECALL_RESET;
    end else begin
      last_reg    <= last_next;
      invalid_reg <= invalid_next;
      load_reg    <= load_next;
      index_reg   <= index_next;
    end
  end

  // Register writes and one-cycle read data
  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = '0;
    if (reg_wr_i && (reg_addr_i == REG_CTRL)) begin
      ctrl_next[CTRL_PASS_LATCH_BIT] = reg_wdata_i[CTRL_PASS_LATCH_BIT];
      ctrl_next[CTRL_FAIL_LOCK_BIT]  = reg_wdata_i[CTRL_FAIL_LOCK_BIT];
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_CTRL: begin
          rdata_next[CTRL_PASS_LATCH_BIT] = pass_latch;
          rdata_next[CTRL_FAIL_LOCK_BIT]  = fail_lock;
        end
        REG_STATUS: begin
          rdata_next[STAT_TEST_BIT]    = (state_reg == ST_TEST);
          rdata_next[STAT_LIVE_BIT]    = live_reg;
          rdata_next[STAT_PASS_BIT]    = pass_reg;
          rdata_next[STAT_UFAIL_BIT]   = ufail_reg;
          rdata_next[STAT_LFAIL_BIT]   = lfail_reg;
          rdata_next[STAT_STANDBY_BIT] = standby_reg;
          rdata_next[STAT_ENABLE_BIT]  = s_enable;
          rdata_next[STAT_INVALID_BIT] = invalid_reg;
        end
        REG_RECALL: begin
          rdata_next[RCL_DIGIT_LSB +: SEL_W] = last_reg;
          rdata_next[RCL_INVALID_BIT]        = invalid_reg;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl_reg  <= CTRL_RESET;
      rdata_reg <= '0;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  // Outputs, all from flip-flops
  assign reg_rdata_o        = rdata_reg;
  assign output_live_flag_o = live_reg;
  assign test_active_o      = (state_reg == ST_TEST);
  assign pass_o             = pass_reg;
  assign upper_fail_o       = ufail_reg;
  assign lower_fail_o       = lfail_reg;
  assign standby_o          = standby_reg;
  assign recall_load_o      = load_reg;
  assign recall_index_o     = index_reg;

endmodule

`default_nettype wire

// [tb/trsp_assertions.sv]
`default_nettype none
module trsp_checker
  import trsp_pkg::*;
#(
  parameter int unsigned PASS_CYC = 8
) (
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic       recall_select_bit0_b_i,
  input wire logic       recall_select_bit1_b_i,
  input wire logic       recall_select_bit2_b_i,
  input wire logic       recall_select_bit3_b_i,
  input wire logic       recall_strobe_i,
  input wire logic       panel_start_i,
  input wire logic       panel_stop_i,
  input wire logic       meas_done_i,
  input wire logic       meas_over_upper_i,
  input wire logic       meas_at_or_below_lower_i,
  input wire logic       hv_residual_i,
  input wire logic       output_live_flag_o,
  input wire logic       test_active_o,
  input wire logic       pass_o,
  input wire logic       upper_fail_o,
  input wire logic       lower_fail_o,
  input wire logic       standby_o,
  input wire logic       recall_load_o,
  input wire logic [3:0] recall_index_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Decoded select digit and judgment moment
  logic [3:0] digit;
  logic       judge;
  assign digit = ~{recall_select_bit3_b_i, recall_select_bit2_b_i,
                   recall_select_bit1_b_i, recall_select_bit0_b_i};
  assign judge = test_active_o && meas_done_i && !panel_stop_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_recall_load: assert property ($rose(recall_strobe_i) && digit <= BCD_MAX
    |-> ##[3:4] recall_load_o && recall_index_o == digit) else $error("recall load wrong");
  a_recall_refuse: assert property ($rose(recall_strobe_i) && digit > BCD_MAX
    |-> ##1 !recall_load_o [*5]) else $error("invalid digit loaded");
  a_load_pulse: assert property (recall_load_o |=> !recall_load_o)
    else $error("load pulse too long");
  a_live_test: assert property (test_active_o |-> output_live_flag_o)
    else $error("live flag low in test");
  a_live_residual: assert property (hv_residual_i |=> output_live_flag_o)
    else $error("live flag low with residue");
  a_standby_busy: assert property (test_active_o || pass_o || upper_fail_o
    || lower_fail_o |-> !standby_o) else $error("standby while busy");
  a_panel_start: assert property (panel_start_i && !panel_stop_i && !test_active_o
    && !upper_fail_o && !lower_fail_o |=> test_active_o) else $error("start ignored");
  a_panel_stop: assert property (panel_stop_i
    |=> !test_active_o && !upper_fail_o && !lower_fail_o) else $error("stop ignored");
  a_upper_fail: assert property (judge && meas_over_upper_i
    |=> upper_fail_o && !lower_fail_o && !pass_o) else $error("upper fail wrong");
  a_lower_fail: assert property (judge && !meas_over_upper_i
    && meas_at_or_below_lower_i |=> lower_fail_o && !upper_fail_o)
    else $error("lower fail wrong");
  a_pass_judge: assert property (judge && !meas_over_upper_i
    && !meas_at_or_below_lower_i |=> pass_o && !test_active_o)
    else $error("pass missing");
endmodule
bind trsp_top trsp_checker #(.PASS_CYC(PASS_CYC)) u_chk (.clk_i, .rst_b_i,
  .recall_select_bit0_b_i, .recall_select_bit1_b_i, .recall_select_bit2_b_i,
  .recall_select_bit3_b_i, .recall_strobe_i, .panel_start_i, .panel_stop_i, .meas_done_i,
  .meas_over_upper_i, .meas_at_or_below_lower_i, .hv_residual_i, .output_live_flag_o,
  .test_active_o, .pass_o, .upper_fail_o, .lower_fail_o, .standby_o, .recall_load_o,
  .recall_index_o);
`default_nettype wire

// [tb/trsp_ctrl_model.sv]
`default_nettype none
module trsp_ctrl_model (
  input  wire logic       clk_i,
  output var  logic [3:0] sel_b_o,
  output var  logic       strobe_o,
  output var  logic       start_o,
  output var  logic       stop_o,
  output var  logic       enable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pulled-up select lines idle high
  initial begin
    sel_b_o = 4'hF;
    {strobe_o, start_o, stop_o, enable_o} = 4'h0;
  end
  // Select set up and held around the strobe rise
  task automatic recall(input logic [3:0] d);
    @(posedge clk_i) sel_b_o <= ~d;
    repeat (3) @(posedge clk_i);
    strobe_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    strobe_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    sel_b_o <= 4'hF;
  endtask
  // Start or stop pin held four cycles
  task automatic hit(input logic stp);
    @(posedge clk_i);
    if (stp) stop_o <= 1'b1;
    else start_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    {start_o, stop_o} <= 2'h0;
  endtask
  // Remote enable level
  task automatic enable(input logic e);
    @(posedge clk_i) enable_o <= e;
  endtask
endmodule
`default_nettype wire

// [tb/tester_remote_signal_port_test.sv]
`default_nettype none
module tester_remote_signal_port_test
  import trsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned PCYC = 8;
  logic        clk_i, rst_b_i, panel_start_i, panel_stop_i, meas_done_i;
  logic        meas_over_upper_i, meas_at_or_below_lower_i, hv_residual_i;
  logic        reg_wr_i, reg_rd_i, strobe, start, stop, enable;
  logic        output_live_flag_o, test_active_o, pass_o, upper_fail_o;
  logic        lower_fail_o, standby_o, recall_load_o;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [3:0]  recall_index_o, sel_b, last_idx;
  logic [5:0]  outs;
  int          error_cnt, num_checks, loads;
  assign outs = {test_active_o, output_live_flag_o, pass_o, upper_fail_o, lower_fail_o,
                 standby_o};
  trsp_ctrl_model ctrl (.clk_i, .sel_b_o(sel_b), .strobe_o(strobe), .start_o(start),
    .stop_o(stop), .enable_o(enable));
  trsp_top #(.PASS_CYC(PCYC)) dut (.clk_i, .rst_b_i, .recall_select_bit0_b_i(sel_b[0]),
    .recall_select_bit1_b_i(sel_b[1]), .recall_select_bit2_b_i(sel_b[2]),
    .recall_select_bit3_b_i(sel_b[3]), .recall_strobe_i(strobe), .remote_start_i(start),
    .remote_stop_i(stop), .remote_enable_i(enable), .panel_start_i, .panel_stop_i,
    .meas_done_i, .meas_over_upper_i, .meas_at_or_below_lower_i, .hv_residual_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .output_live_flag_o,
    .test_active_o, .pass_o, .upper_fail_o, .lower_fail_o, .standby_o, .recall_load_o,
    .recall_index_o);
  // Clock
  always #4 clk_i = ~clk_i;
  // Recall load monitor
  always @(posedge clk_i) if (recall_load_o === 1'b1) begin
    loads++;
    last_idx = recall_index_o;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i) reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i) reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask
  // Panel start 4, stop 2, done 1 for one cycle
  task automatic go(input logic [2:0] w, input logic [1:0] m);
    @(posedge clk_i);
    panel_start_i            <= w[2];
    panel_stop_i             <= w[1];
    meas_done_i              <= w[0];
    meas_over_upper_i        <= m[1];
    meas_at_or_below_lower_i <= m[0];
    @(posedge clk_i);
    panel_start_i <= 1'b0;
    panel_stop_i  <= 1'b0;
    meas_done_i   <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    #1 chk(32'(outs), 32'h01);
    rd(REG_STATUS, 32'h20);
    wr(REG_STATUS, 32'hFF);
    rd(REG_STATUS, 32'h20);
    rd(8'h0C, 32'h0);
    rd(REG_RECALL, 32'h0);
  endtask
  task automatic t_recall;
    int n;
    for (int d = 0; d < 10; d++) begin
      n = loads;
      ctrl.recall(4'(d));
      chk(32'(loads - n), 32'h1);
      chk(32'(last_idx), 32'(d));
    end
    n = loads;
    ctrl.recall(4'hC);
    chk(32'(loads - n), 32'h0);
    rd(REG_RECALL, 32'h1C);
  endtask
  task automatic t_pass;
    int n;
    go(3'h4, 2'h0);
    chk(32'(outs), 32'h30);
    go(3'h1, 2'h0);
    chk(32'(outs), 32'h08);
    n = 1;
    for (int k = 0; k < 20 && pass_o === 1'b1; k++) begin
      @(posedge clk_i) #1;
      if (pass_o === 1'b1) n++;
    end
    chk(32'(n), 32'(PCYC));
    wr(REG_CTRL, 32'h1);
    go(3'h4, 2'h0);
    go(3'h1, 2'h0);
    repeat (3 * PCYC) @(posedge clk_i);
    #1 chk(32'(pass_o), 32'h1);
    rd(REG_CTRL, 32'h1);
    go(3'h2, 2'h0);
    chk(32'(outs), 32'h01);
    wr(REG_CTRL, 32'h0);
  endtask
  task automatic t_fail;
    for (int k = 1; k < 4; k++) begin
      go(3'h4, 2'h0);
      go(3'h1, 2'(k));
      chk(32'(outs), (k > 1) ? 32'h04 : 32'h02);
      go(3'h4, 2'h0);
      chk(32'(outs), (k > 1) ? 32'h04 : 32'h02);
      go(3'h2, 2'h0);
      chk(32'(outs), 32'h01);
    end
  endtask
  task automatic t_remote;
    ctrl.hit(1'b0);
    repeat (3) @(posedge clk_i);
    #1 chk(32'(outs), 32'h01);
    ctrl.enable(1'b1);
    ctrl.hit(1'b0);
    repeat (2) @(posedge clk_i);
    #1 chk(32'(outs), 32'h30);
    rd(REG_STATUS, 32'hC3);
    @(posedge clk_i) hv_residual_i <= 1'b1;
    ctrl.hit(1'b1);
    repeat (2) @(posedge clk_i);
    #1 chk(32'(outs), 32'h11);
    @(posedge clk_i) hv_residual_i <= 1'b0;
    wr(REG_CTRL, 32'h2);
    ctrl.hit(1'b0);
    repeat (2) @(posedge clk_i);
    go(3'h1, 2'h2);
    ctrl.hit(1'b1);
    repeat (2) @(posedge clk_i);
    #1 chk(32'(outs), 32'h04);
    wr(REG_CTRL, 32'h4);
    repeat (2) @(posedge clk_i);
    #1 chk(32'(outs), 32'h01);
    rd(REG_CTRL, 32'h0);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end
  // Main sequence
  initial begin
    {clk_i, rst_b_i, panel_start_i, panel_stop_i, meas_done_i, hv_residual_i} = 6'h0;
    {meas_over_upper_i, meas_at_or_below_lower_i, reg_wr_i, reg_rd_i} = 4'h0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_recall();
    t_pass();
    t_fail();
    t_remote();
    final_report();
  end
endmodule
`default_nettype wire
